// ==== bssr_map.vh ====
`ifndef BSSR_MAP_VH
`define BSSR_MAP_VH
// boot source encodings (one-hot)
`define BSSR_SRC_FLASH   3'h1
`define BSSR_SRC_SYSMEM  3'h2
`define BSSR_SRC_SRAM    3'h4
// memory region bases
`define BSSR_FLASH_BASE  32'h08000000
`define BSSR_SYSMEM_BASE 32'h1fff0000
`define BSSR_SRAM_BASE   32'h20000000
`define BSSR_ZERO_BASE   32'h00000000
// size of the aliased window at address zero
`define BSSR_ALIAS_SIZE  32'h00010000
// cycles counted after reset release before straps are captured
`define BSSR_SETTLE_CYC  4'h4
`endif

// ==== bssr_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module bssr_sync #(
   parameter WIDTH = 2
) (
   input  wire             ref_clk_i,  // system clock
   input  wire             resetn_i,   // synchronous reset, active low
   input  wire             ce_i,       // clock enable
   input  wire [WIDTH-1:0] async_i,    // pin levels
   output reg  [WIDTH-1:0] stable_o    // filtered level
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         stage1   <= {WIDTH{1'b0}};
         stage2   <= {WIDTH{1'b0}};
         stage3   <= {WIDTH{1'b0}};
         stable_o <= {WIDTH{1'b0}};
      end else if (ce_i) begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         // a change counts once stages two and three agree
         if (stage2 == stage3) begin
            stable_o <= stage3;
         end
      end
   end
endmodule
`default_nettype wire

// ==== bssr_boot_select.v ====
// Contract
// - straps sampled at every reset; boot selection held until next reset.
// - primary strap low selects main flash, secondary strap ignored.
// - primary high, secondary low selects system memory.
// - both straps high selects embedded SRAM.
// - flash boot aliases flash base onto address zero.
// - system-memory boot aliases system flash base onto address zero.
// - SRAM boot applies no alias; SRAM only at its own base.
`timescale 1ns/1ps
`default_nettype none
`include "bssr_map.vh"
module bssr_boot_select (
   input  wire        ref_clk_i,                 // 25 MHz system clock
   input  wire        resetn_i,                  // synchronous reset, active low
   input  wire        ce_i,                      // clock enable, freezes state when low
   input  wire        boot_strap_primary_i,      // first boot strap pin
   input  wire        boot_strap_secondary_i,    // second boot strap pin
   input  wire        addr_valid_i,              // bus address request valid
   input  wire [31:0] addr_i,                    // bus address to decode
   output reg  [2:0]  boot_src_o,                // one-hot boot source
   output reg         boot_ready_o,              // selection latched and stable
   output reg         remap_valid_o,             // translated address valid
   output reg  [31:0] remap_addr_o,              // translated physical address
   output reg         alias_hit_o                // request fell in zero alias window under flash or system-memory boot
);
   localparam ST_CAPTURE = 2'h1;
   localparam ST_HOLD    = 2'h2;

   reg  [1:0]  state;
   reg  [3:0]  settle_cnt;
   wire [1:0]  strap_stable;
   wire        in_alias;

   // resolve straps to one-hot source
   function [2:0] decode_src;
      input primary;
      input secondary;
      begin
         if (!primary) begin
            decode_src = `BSSR_SRC_FLASH;
         end else if (!secondary) begin
            decode_src = `BSSR_SRC_SYSMEM;
         end else begin
            decode_src = `BSSR_SRC_SRAM;
         end
      end
   endfunction

   bssr_sync #(
      .WIDTH (2)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .ce_i      (ce_i),
      .async_i   ({boot_strap_secondary_i, boot_strap_primary_i}),
      .stable_o  (strap_stable)
   );

   // capture after release, then freeze until next reset
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state        <= ST_CAPTURE;
         settle_cnt   <= 4'h0;
         boot_src_o   <= `BSSR_SRC_FLASH;
         boot_ready_o <= 1'b0;
      end else if (ce_i) begin
         case (state)
            ST_CAPTURE: begin
               // relies on straps held steady through capture
               if (settle_cnt == `BSSR_SETTLE_CYC) begin
                  boot_src_o   <= decode_src(strap_stable[0], strap_stable[1]);
                  boot_ready_o <= 1'b1;
                  state        <= ST_HOLD;
               end else begin
                  settle_cnt <= settle_cnt + 4'h1;
               end
            end
            ST_HOLD: begin
               state <= ST_HOLD;
            end
            default: begin
               state <= ST_CAPTURE;
            end
         endcase
      end
   end

   assign in_alias = (addr_i < `BSSR_ALIAS_SIZE);

   // address translation for the low window
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         remap_valid_o <= 1'b0;
         remap_addr_o  <= 32'h00000000;
         alias_hit_o   <= 1'b0;
      end else if (ce_i) begin
         remap_valid_o <= addr_valid_i & boot_ready_o;
         alias_hit_o   <= 1'b0;
         remap_addr_o  <= addr_i;
         if (addr_valid_i && boot_ready_o && in_alias) begin
            if (boot_src_o == `BSSR_SRC_FLASH) begin
               remap_addr_o <= `BSSR_FLASH_BASE | addr_i;
               alias_hit_o  <= 1'b1;
            end else if (boot_src_o == `BSSR_SRC_SYSMEM) begin
               remap_addr_o <= `BSSR_SYSMEM_BASE | addr_i;
               alias_hit_o  <= 1'b1;
            end else begin
               remap_addr_o <= addr_i;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== bssr_strap_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bssr_strap_model (
   input  wire logic [1:0] mode_i,      // bit 1 primary, bit 0 secondary
   output wire logic       primary_o,   // primary strap level
   output wire logic       secondary_o  // secondary strap level
);
   assign primary_o   = mode_i[1];
   assign secondary_o = mode_i[0];
endmodule
`default_nettype wire

// ==== bssr_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module bssr_asserts (
   input wire logic        ref_clk_i,              // clock
   input wire logic        resetn_i,               // reset
   input wire logic        ce_i,                   // enable
   input wire logic        boot_strap_primary_i,   // strap
   input wire logic        boot_strap_secondary_i, // strap
   input wire logic        addr_valid_i,           // request
   input wire logic [31:0] addr_i,                 // address
   input wire logic [2:0]  boot_src_o,             // source
   input wire logic        boot_ready_o,           // latched
   input wire logic        remap_valid_o,          // answer
   input wire logic [31:0] remap_addr_o,           // translated
   input wire logic        alias_hit_o             // alias
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic lo;
   logic go;
   assign lo = addr_i < 32'h00010000;
   assign go = ce_i && addr_valid_i && boot_ready_o;
   a_src_held: assert property (boot_ready_o && $past(boot_ready_o) |-> $stable(boot_src_o))
      else $error("boot source changed");
   a_flash_pick: assert property ($rose(boot_ready_o) && !boot_strap_primary_i |-> boot_src_o == 3'h1)
      else $error("flash not picked");
   a_sys_pick: assert property ($rose(boot_ready_o) && boot_strap_primary_i && !boot_strap_secondary_i
      |-> boot_src_o == 3'h2)
      else $error("system memory not picked");
   a_sram_pick: assert property ($rose(boot_ready_o) && boot_strap_primary_i && boot_strap_secondary_i
      |-> boot_src_o == 3'h4)
      else $error("sram not picked");
   a_flash_alias: assert property (go && lo && boot_src_o == 3'h1 |=> remap_valid_o && alias_hit_o
      && remap_addr_o == ($past(addr_i) | 32'h08000000))
      else $error("flash alias wrong");
   a_sys_alias: assert property (go && lo && boot_src_o == 3'h2 |=> remap_valid_o && alias_hit_o
      && remap_addr_o == ($past(addr_i) | 32'h1fff0000))
      else $error("system memory alias wrong");
   a_sram_plain: assert property (go && boot_src_o == 3'h4 |=> remap_valid_o && !alias_hit_o
      && remap_addr_o == $past(addr_i))
      else $error("sram address altered");
endmodule
bind bssr_boot_select bssr_asserts chk (.*);
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk = 0;
   logic        rst_n = 0;
   logic [1:0]  mode = 0;
   logic        av = 0;
   logic        ce = 1;
   logic [31:0] addr = 0;
   wire         p, s, rdy, rv, hit;
   wire  [2:0]  src;
   wire  [31:0] ra;
   int          err_count = 0;
   int          check_count = 0;
   bssr_strap_model strap (.mode_i(mode), .primary_o(p), .secondary_o(s));
   bssr_boot_select dut (.ref_clk_i(clk), .resetn_i(rst_n), .ce_i(ce),
      .boot_strap_primary_i(p), .boot_strap_secondary_i(s), .addr_valid_i(av), .addr_i(addr),
      .boot_src_o(src), .boot_ready_o(rdy), .remap_valid_o(rv), .remap_addr_o(ra),
      .alias_hit_o(hit));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      check_count++;
      if (v !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, v);
      end
   endtask
   task automatic boot(input logic [1:0] m);
      @(posedge clk);
      rst_n <= 0;
      mode <= m;
      repeat (20) @(posedge clk);
      rst_n <= 1;
      repeat (12) @(posedge clk);
      #1 chk("ready", 1, rdy);
   endtask
   task automatic req(input logic [31:0] a, input logic [31:0] e, input logic h);
      @(posedge clk);
      av <= 1;
      addr <= a;
      @(posedge clk);
      av <= 0;
      #1 chk("valid", 1, rv);
      chk("addr", e, ra);
      chk("hit", h, hit);
   endtask
   task automatic t_flash;
      boot(2'b01);
      chk("src", 3'h1, src);
      req(32'h00000100, 32'h08000100, 1);
      req(32'h20000004, 32'h20000004, 0);
   endtask
   task automatic t_sys;
      boot(2'b10);
      chk("src", 3'h2, src);
      req(32'h0000fffc, 32'h1ffffffc, 1);
   endtask
   task automatic t_sram;
      boot(2'b11);
      chk("src", 3'h4, src);
      req(32'h00000000, 32'h00000000, 0);
      mode <= 2'b00;
      repeat (8) @(posedge clk);
      chk("src", 3'h4, src);
   endtask
   task automatic t_hold;
      boot(2'b00);
      chk("src", 3'h1, src);
      @(posedge clk);
      ce <= 0;
      av <= 1;
      addr <= 32'h00000010;
      repeat (3) @(posedge clk);
      #1 chk("frozen", 0, rv);
      @(posedge clk);
      ce <= 1;
      @(posedge clk);
      av <= 0;
      #1 chk("valid", 1, rv);
      chk("addr", 32'h08000010, ra);
   endtask
   task automatic stop_test;
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial forever #20 clk = ~clk;
   initial begin
      #50000;
      err_count++;
      stop_test;
   end
   initial begin
      t_flash;
      t_sys;
      t_sram;
      t_hold;
      stop_test;
   end
endmodule
`default_nettype wire
